// ==== hw/cwrc_pkg.sv ====
// Purpose: shared constants and carrier types for the clock watchdog recovery control
// Assumes: 125 MHz system clock, control bytes addressed by byte number
// Notes: long prescale counts are defaults for top-level parameters
package cwrc_pkg;

  localparam logic [7:0] ADDR_WD_CTRL = 8'h09;
  localparam logic [7:0] ADDR_SKEW = 8'h0a;
  localparam logic [7:0] ADDR_REC_N = 8'h0b;
  localparam logic [7:0] ADDR_REC_M = 8'h0c;

  localparam logic [7:0] RST_WD_CTRL = 8'h00;
  localparam logic [7:0] RST_SKEW = 8'h00;
  localparam logic [7:0] RST_REC_N = 8'h00;
  localparam logic [7:0] RST_REC_M = 8'h00;

  // control byte fields
  localparam int BIT_USB_DRV = 7;
  localparam int BIT_PCI_CLOCK_DRIVE_SELECT = 6;
  localparam int BIT_MID_DRV = 5;
  localparam int BIT_WD_RST_EN = 4;
  localparam int BIT_FC_RST_EN = 3;
  localparam int BIT_TO_FLAG = 2;
  localparam int BIT_GUARD_TIMER_ENABLE = 1;
  // skew byte fields
  localparam int CPU_SKEW_HI = 7;
  localparam int CPU_SKEW_LO = 5;
  localparam int PCI_SKEW_HI = 3;
  localparam int PCI_SKEW_LO = 2;
  localparam int MID_SKEW_HI = 1;
  localparam int MID_SKEW_LO = 0;
  // recovery select byte fields
  localparam int BIT_REC_SEL = 7;
  localparam int REC_M_HI = 6;

  // timing
  localparam int unsigned CLK_KHZ = 125000;
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned PRESCALE_SHORT_MS = 150;
  localparam int unsigned PRESCALE_LONG_MS = 2500;
  localparam int unsigned PRESCALE_SHORT_CYC = PRESCALE_SHORT_MS * CLK_KHZ;
  localparam int unsigned PRESCALE_LONG_CYC = PRESCALE_LONG_MS * CLK_KHZ;
  localparam int unsigned RESET_PULSE_NS = 1000;
  localparam int unsigned RESET_PULSE_CYC =
    (RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] RESET_PULSE_CNT = RESET_PULSE_CYC[7:0];
  localparam logic [2:0] STRAP_SETTLE_CNT = 3'h4;
  localparam int TICK_W = 29;

  typedef struct packed {
    logic usb_clock_drive_select;
    logic pci_clock_drive_select;
    logic mid_clock_drive_select;
  } cwrc_drive_t;

  typedef struct packed {
    logic [2:0] cpu_skew_code;
    logic [1:0] pci_skew_code;
    logic [1:0] mid_skew_code;
  } cwrc_skew_t;

endpackage : cwrc_pkg

// ==== hw/cwrc_sync.sv ====
// Purpose: three-stage synchroniser for a pin bus
// Assumes: each bit sampled independently
// Notes: output moves only when the second and third stages agree
`timescale 1ns/1ps
module cwrc_sync #(
  parameter int W = 5
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] level_out
);

  logic [W-1:0] stage1;
  logic [W-1:0] stage2;
  logic [W-1:0] stage3;

  always_ff @(posedge clk) begin
    if (srst) begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
    end else begin
      stage1 <= pin_in;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge clk) begin
      if (srst) begin
        level_out[i] <= 1'b0;
      end else if (stage2[i] == stage3[i]) begin
        level_out[i] <= stage3[i];
      end
    end
  end

endmodule : cwrc_sync

// ==== hw/cwrc_wdog.sv ====
// Purpose: watchdog down-counter with prescaled ticks
// Assumes: enable, start and settings come from the same clock
// Notes: time-out equals timeout_value prescale periods; a value of 0 expires on the first tick
`timescale 1ns/1ps
module cwrc_wdog #(
  parameter int unsigned SHORT_CYC = cwrc_pkg::PRESCALE_SHORT_CYC,
  parameter int unsigned LONG_CYC = cwrc_pkg::PRESCALE_LONG_CYC
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic enable,
  input wire logic start,
  input wire logic [4:0] timeout_value,
  input wire logic timeout_prescale,
  output logic running,
  output logic expire
);

  logic [cwrc_pkg::TICK_W-1:0] tick_cnt;
  logic [cwrc_pkg::TICK_W-1:0] tick_limit;
  logic [4:0] count;
  logic tick_end;

  assign tick_limit = timeout_prescale ? cwrc_pkg::TICK_W'(LONG_CYC - 1)
                                       : cwrc_pkg::TICK_W'(SHORT_CYC - 1);
  assign tick_end = (tick_cnt >= tick_limit);

  always_ff @(posedge clk) begin
    if (srst || !enable) begin
      // disabled: stopped and reloaded
      running <= 1'b0;
      count <= timeout_value;
      tick_cnt <= '0;
    end else if (start && !running) begin
      // counting starts only on a frequency change
      running <= 1'b1;
      count <= timeout_value;
      tick_cnt <= '0;
    end else if (running) begin
      if (tick_end) begin
        tick_cnt <= '0;
        if (count <= 5'h01) begin
          running <= 1'b0;
        end else begin
          count <= count - 5'h01;
        end
      end else begin
        tick_cnt <= tick_cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      expire <= 1'b0;
    end else begin
      // an accepted request on the last tick must not swallow the time-out
      expire <= enable && running && tick_end && (count <= 5'h01);
    end
  end

endmodule : cwrc_wdog

// ==== hw/cwrc_ctrl.sv ====
// Purpose: watchdog, reset pulse, recovery lock, drive and skew control bytes
// Assumes: byte-addressed control port decoded from the management bus
// Notes: frequency-change writes arrive as request pulses and are gated here
`timescale 1ns/1ps

module cwrc_ctrl #(
  parameter int unsigned PRESCALE_SHORT_CYC = cwrc_pkg::PRESCALE_SHORT_CYC,
  parameter int unsigned PRESCALE_LONG_CYC = cwrc_pkg::PRESCALE_LONG_CYC
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic [4:0] strap_freq_code,
  input wire logic [4:0] sel_freq_code,
  input wire logic freq_source_override,
  input wire logic [4:0] timeout_value,
  input wire logic timeout_prescale,
  input wire logic freq_write_req,
  output logic freq_write_accept,
  output cwrc_pkg::cwrc_drive_t drive_select,
  output cwrc_pkg::cwrc_skew_t skew_select,
  output logic [4:0] cpu_ratio_code,
  output logic [4:0] latched_strap_code,
  output logic recovery_active,
  output logic recovery_use_nm,
  output logic recovery_use_strap,
  output logic [7:0] recovery_n_value,
  output logic [6:0] recovery_m_value,
  output logic timeout_flag,
  output logic sys_reset_pulse
);

  typedef enum logic [1:0] {
    CWRC_STRAP_WAIT,
    CWRC_STRAP_DONE
  } cwrc_strap_state_t;

  logic timeout_reset_enable;
  logic freq_change_reset_enable;
  logic guard_timer_enable;
  logic recovery_source_select;
  logic wr_ctrl;
  logic wr_skew;
  logic wr_n;
  logic wr_m;
  logic next_accept;
  logic wd_expire;
  logic wd_running;
  logic reset_trigger;
  logic [7:0] pulse_cnt;
  logic [4:0] strap_sync;
  logic [2:0] settle_cnt;
  cwrc_strap_state_t strap_state;

  assign wr_ctrl = reg_wr && (reg_addr == cwrc_pkg::ADDR_WD_CTRL);
  assign wr_skew = reg_wr && (reg_addr == cwrc_pkg::ADDR_SKEW);
  assign wr_n = reg_wr && (reg_addr == cwrc_pkg::ADDR_REC_N);
  assign wr_m = reg_wr && (reg_addr == cwrc_pkg::ADDR_REC_M);
  // a request in the time-out cycle is refused too, since the lock is taken then
  assign next_accept = freq_write_req && !recovery_active && !wd_expire;

  // ---------------- control byte
  always_ff @(posedge clk) begin
    if (srst) begin
      drive_select <= '0;
      timeout_reset_enable <= 1'b0;
      freq_change_reset_enable <= 1'b0;
      guard_timer_enable <= 1'b0;
    end else if (wr_ctrl) begin
      drive_select.usb_clock_drive_select <= reg_wdata[cwrc_pkg::BIT_USB_DRV];
      drive_select.pci_clock_drive_select <= reg_wdata[cwrc_pkg::BIT_PCI_CLOCK_DRIVE_SELECT];
      drive_select.mid_clock_drive_select <= reg_wdata[cwrc_pkg::BIT_MID_DRV];
      timeout_reset_enable <= reg_wdata[cwrc_pkg::BIT_WD_RST_EN];
      freq_change_reset_enable <= reg_wdata[cwrc_pkg::BIT_FC_RST_EN];
      guard_timer_enable <= reg_wdata[cwrc_pkg::BIT_GUARD_TIMER_ENABLE];
    end
  end

  // set wins over a same-cycle clear so no time-out is lost
  always_ff @(posedge clk) begin
    if (srst) begin
      timeout_flag <= 1'b0;
    end else if (wd_expire) begin
      timeout_flag <= 1'b1;
    end else if (wr_ctrl && reg_wdata[cwrc_pkg::BIT_TO_FLAG]) begin
      timeout_flag <= 1'b0;
    end
  end

  // ---------------- skew and recovery bytes
  always_ff @(posedge clk) begin
    if (srst) begin
      skew_select <= cwrc_pkg::RST_SKEW[6:0];
    end else if (wr_skew) begin
      skew_select.cpu_skew_code <=
        reg_wdata[cwrc_pkg::CPU_SKEW_HI:cwrc_pkg::CPU_SKEW_LO];
      skew_select.pci_skew_code <=
        reg_wdata[cwrc_pkg::PCI_SKEW_HI:cwrc_pkg::PCI_SKEW_LO];
      skew_select.mid_skew_code <=
        reg_wdata[cwrc_pkg::MID_SKEW_HI:cwrc_pkg::MID_SKEW_LO];
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      recovery_n_value <= cwrc_pkg::RST_REC_N;
    end else if (wr_n) begin
      recovery_n_value <= reg_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      recovery_source_select <= cwrc_pkg::RST_REC_M[cwrc_pkg::BIT_REC_SEL];
      recovery_m_value <= cwrc_pkg::RST_REC_M[cwrc_pkg::REC_M_HI:0];
    end else if (wr_m) begin
      recovery_source_select <= reg_wdata[cwrc_pkg::BIT_REC_SEL];
      recovery_m_value <= reg_wdata[cwrc_pkg::REC_M_HI:0];
    end
  end

  // ---------------- read port, one cycle latency
  always_ff @(posedge clk) begin
    if (srst) begin
      reg_rvalid <= 1'b0;
      reg_rdata <= 8'h00;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        case (reg_addr)
          cwrc_pkg::ADDR_WD_CTRL: reg_rdata <= {drive_select, timeout_reset_enable,
            freq_change_reset_enable, timeout_flag, guard_timer_enable, 1'b0};
          cwrc_pkg::ADDR_SKEW: reg_rdata <= {skew_select.cpu_skew_code, 1'b0,
            skew_select.pci_skew_code, skew_select.mid_skew_code};
          cwrc_pkg::ADDR_REC_N: reg_rdata <= recovery_n_value;
          cwrc_pkg::ADDR_REC_M: reg_rdata <= {recovery_source_select, recovery_m_value};
          default: reg_rdata <= 8'h00;
        endcase
      end
    end
  end

  // ---------------- strap capture after reset release
  cwrc_sync #(
    .W(5)
  ) u_strap_sync (
    .clk(clk),
    .srst(srst),
    .pin_in(strap_freq_code),
    .level_out(strap_sync)
  );

  // wait for the synchroniser to fill before taking the strap once
  always_ff @(posedge clk) begin
    if (srst) begin
      strap_state <= CWRC_STRAP_WAIT;
      settle_cnt <= 3'h0;
      latched_strap_code <= 5'h00;
    end else begin
      case (strap_state)
        CWRC_STRAP_WAIT: begin
          if (settle_cnt == cwrc_pkg::STRAP_SETTLE_CNT) begin
            latched_strap_code <= strap_sync;
            strap_state <= CWRC_STRAP_DONE;
          end else begin
            settle_cnt <= settle_cnt + 3'h1;
          end
        end
        CWRC_STRAP_DONE: strap_state <= CWRC_STRAP_DONE;
        default: strap_state <= CWRC_STRAP_WAIT;
      endcase
    end
  end

  // ---------------- frequency path
  always_ff @(posedge clk) begin
    if (srst) begin
      cpu_ratio_code <= 5'h00;
    end else begin
      cpu_ratio_code <= freq_source_override ? sel_freq_code : latched_strap_code;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      freq_write_accept <= 1'b0;
    end else begin
      freq_write_accept <= next_accept;
    end
  end

  // ---------------- watchdog and recovery lock
  cwrc_wdog #(
    .SHORT_CYC(PRESCALE_SHORT_CYC),
    .LONG_CYC(PRESCALE_LONG_CYC)
  ) u_wdog (
    .clk(clk),
    .srst(srst),
    .enable(guard_timer_enable),
    .start(freq_write_accept),
    .timeout_value(timeout_value),
    .timeout_prescale(timeout_prescale),
    .running(wd_running),
    .expire(wd_expire)
  );

  // a time-out in the same cycle as the unlocking write still locks
  always_ff @(posedge clk) begin
    if (srst) begin
      recovery_active <= 1'b0;
    end else if (wd_expire) begin
      recovery_active <= 1'b1;
    end else if (wr_ctrl && !reg_wdata[cwrc_pkg::BIT_GUARD_TIMER_ENABLE]) begin
      recovery_active <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      recovery_use_nm <= 1'b0;
      recovery_use_strap <= 1'b0;
    end else begin
      recovery_use_nm <= (recovery_active || wd_expire) && recovery_source_select;
      recovery_use_strap <= (recovery_active || wd_expire) && !recovery_source_select;
    end
  end

  // ---------------- reset pulse
  assign reset_trigger = (wd_expire && timeout_reset_enable)
    || (freq_write_accept && freq_change_reset_enable);

  always_ff @(posedge clk) begin
    if (srst) begin
      pulse_cnt <= 8'h00;
    end else if (reset_trigger) begin
      pulse_cnt <= cwrc_pkg::RESET_PULSE_CNT;
    end else if (pulse_cnt != 8'h00) begin
      pulse_cnt <= pulse_cnt - 8'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      sys_reset_pulse <= 1'b0;
    end else begin
      sys_reset_pulse <= reset_trigger || (pulse_cnt > 8'h01);
    end
  end

  // ---------------- assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  property p_drive;
    wr_ctrl |=> drive_select == $past(reg_wdata[7:5]);
  endproperty
  a_drive: assert property (p_drive) else $error("drive select not taken");

  property p_wd_reset;
    wd_expire && timeout_reset_enable |=> sys_reset_pulse [*8];
  endproperty
  a_wd_reset: assert property (p_wd_reset) else $error("no reset on time-out");

  property p_fc_reset;
    freq_write_accept && freq_change_reset_enable |=> sys_reset_pulse;
  endproperty
  a_fc_reset: assert property (p_fc_reset) else $error("no reset on freq change");

  property p_no_reset;
    !sys_reset_pulse && !reset_trigger |=> !sys_reset_pulse;
  endproperty
  a_no_reset: assert property (p_no_reset) else $error("spurious reset pulse");

  property p_flag_clear;
    wr_ctrl && reg_wdata[2] && !wd_expire |=> !timeout_flag;
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("flag not cleared");

  property p_flag_set;
    wd_expire |=> timeout_flag && recovery_active ##1 recovery_use_nm != recovery_use_strap;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("time-out not recorded");

  property p_lock;
    recovery_active && freq_write_req |=> !freq_write_accept;
  endproperty
  a_lock: assert property (p_lock) else $error("write accepted while locked");

  property p_unlock;
    wr_ctrl && !reg_wdata[1] && !wd_expire |=> !recovery_active ##1 !wd_running;
  endproperty
  a_unlock: assert property (p_unlock) else $error("disable did not unlock");

  property p_skew;
    wr_skew |=> skew_select.cpu_skew_code == $past(reg_wdata[7:5])
      && skew_select.mid_skew_code == $past(reg_wdata[1:0]);
  endproperty
  a_skew: assert property (p_skew) else $error("skew code not taken");

  property p_ratio;
    !freq_source_override |=> cpu_ratio_code == $past(latched_strap_code);
  endproperty
  a_ratio: assert property (p_ratio) else $error("ratio not from strap");

  property p_idle;
    !wd_running && !freq_write_accept |=> !wd_expire;
  endproperty
  a_idle: assert property (p_idle) else $error("expire without running");

  c_timeout: cover property (wd_expire ##1 recovery_active);
  c_unlock: cover property (recovery_active ##1 !recovery_active);
  c_fc_reset: cover property (freq_write_accept && freq_change_reset_enable);

endmodule : cwrc_ctrl

// ==== test/cwrc_host_model.sv ====
// Purpose: management host and system reset sink facing the control block
// Assumes: one byte per strobe, strobes launched by non-blocking assignment at a rising edge
// Notes: idle address and data lines carry the inverse of the last value
`timescale 1ns/1ps
module cwrc_host_model (
  input wire logic clk,
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic freq_write_req,
  input wire logic freq_write_accept,
  input wire logic sys_reset_pulse
);
  int rst_cnt;
  int rst_width;

  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    freq_write_req = 1'b0;
    rst_cnt = 0;
    rst_width = 0;
  end

  // width of the last finished reset pulse, as the system sees it
  always @(posedge clk) begin
    if (sys_reset_pulse === 1'b1) begin
      rst_cnt <= rst_cnt + 1;
    end else if (rst_cnt != 0) begin
      rst_width <= rst_cnt;
      rst_cnt <= 0;
    end
  end

  task automatic xfer(input logic wr, input logic [7:0] addr, input logic [7:0] data);
    @(posedge clk);
    reg_wr <= wr;
    reg_rd <= ~wr;
    reg_addr <= addr;
    reg_wdata <= data;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    // released lines must never look like the byte just sent
    reg_addr <= ~addr;
    reg_wdata <= ~data;
  endtask : xfer

  task automatic freq(output logic acc);
    @(posedge clk);
    freq_write_req <= 1'b1;
    @(posedge clk);
    freq_write_req <= 1'b0;
    #1 acc = freq_write_accept;
  endtask : freq
endmodule : cwrc_host_model

// ==== test/tb_clock_watchdog_recovery_ctrl.sv ====
// Purpose: self-checking bench for the clock watchdog recovery control
// Assumes: prescale periods shortened to 4 and 8 cycles
// Notes: read data is checked against a queue of expected bytes
`timescale 1ns/1ps
module tb_clock_watchdog_recovery_ctrl;
  localparam int unsigned SHORT = 4;
  localparam int unsigned LONG = 8;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic reg_wr, reg_rd, reg_rvalid, freq_write_req, freq_write_accept;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, recovery_n_value;
  logic [6:0] recovery_m_value;
  logic [4:0] strap_freq_code, sel_freq_code, timeout_value, cpu_ratio_code, latched_strap_code;
  logic freq_source_override, timeout_prescale, recovery_active;
  logic recovery_use_nm, recovery_use_strap, timeout_flag, sys_reset_pulse;
  cwrc_pkg::cwrc_drive_t drive_select;
  cwrc_pkg::cwrc_skew_t skew_select;
  int error_cnt = 0;
  int compares = 0;
  logic [7:0] exp_q[$];
  logic [7:0] rn, rm, v;
  logic acc;

  always #4 clk = ~clk;

  cwrc_ctrl #(.PRESCALE_SHORT_CYC(SHORT), .PRESCALE_LONG_CYC(LONG)) cwrc_ctrl_inst (
    .clk(clk), .srst(srst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .strap_freq_code(strap_freq_code), .sel_freq_code(sel_freq_code),
    .freq_source_override(freq_source_override), .timeout_value(timeout_value),
    .timeout_prescale(timeout_prescale), .freq_write_req(freq_write_req),
    .freq_write_accept(freq_write_accept), .drive_select(drive_select),
    .skew_select(skew_select), .cpu_ratio_code(cpu_ratio_code),
    .latched_strap_code(latched_strap_code), .recovery_active(recovery_active),
    .recovery_use_nm(recovery_use_nm), .recovery_use_strap(recovery_use_strap),
    .recovery_n_value(recovery_n_value), .recovery_m_value(recovery_m_value),
    .timeout_flag(timeout_flag), .sys_reset_pulse(sys_reset_pulse)
  );

  cwrc_host_model cwrc_host_model_inst (
    .clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .freq_write_req(freq_write_req),
    .freq_write_accept(freq_write_accept), .sys_reset_pulse(sys_reset_pulse)
  );

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic results();
    $display("compares %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : results

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    cwrc_host_model_inst.xfer(1'b1, a, d);
    step(1);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    cwrc_host_model_inst.xfer(1'b0, a, 8'h00);
    step(1);
  endtask : rd

  task automatic wait_flag(input int lim);
    int n;
    n = 0;
    while (timeout_flag !== 1'b1 && n < lim) begin
      step(1);
      n++;
    end
  endtask : wait_flag

  // the old value of a register output is the one that stood through the cycle
  always @(posedge clk) begin
    if (reg_rvalid === 1'b1) begin
      check("rdata", reg_rdata, (exp_q.size() > 0) ? exp_q.pop_front() : 8'hxx);
    end
  end

  initial begin
    #(20000 * 8);
    error_cnt++;
    $display("Error watchdog expected end seen hang");
    results();
  end

  initial begin
    void'($urandom(32'h59ce));
    strap_freq_code = 5'($urandom());
    sel_freq_code = 5'h00;
    freq_source_override = 1'b0;
    timeout_value = 5'h03;
    timeout_prescale = 1'b0;
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    step(7);
    check("latched", 8'(latched_strap_code), 8'(strap_freq_code));
    check("ratio", 8'(cpu_ratio_code), 8'(strap_freq_code));
    rd(8'h09, 8'h00);
    rd(8'h0a, 8'h00);
    rd(8'h0b, 8'h00);
    rd(8'h0c, 8'h00);
    rd(8'h05, 8'h00);
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      rn = 8'($urandom());
      v = {3'(i), 1'b1, rn[3:0]};
      wr(8'h0a, v);
      check("skew", 8'(skew_select), {1'b0, v[7:5], v[3:0]});
      rd(8'h0a, v & 8'hef);
    end
    for (int j = 0; j < 3; j++) begin
      wr(8'h09, (8'h20 << j) | 8'h01);
      check("drive", 8'(drive_select), 8'h01 << j);
    end
    rd(8'h09, 8'h80);
    @(posedge clk);
    sel_freq_code <= ~strap_freq_code;
    freq_source_override <= 1'b1;
    step(3);
    check("ratio_sw", 8'(cpu_ratio_code), {3'h0, ~strap_freq_code});
    $display("test drive skew ratio done");
    rn = 8'($urandom());
    rm = 8'($urandom());
    wr(8'h0b, rn);
    wr(8'h0c, {1'b1, rm[6:0]});
    check("rec_n", recovery_n_value, rn);
    check("rec_m", 8'(recovery_m_value), {1'b0, rm[6:0]});
    rd(8'h0c, {1'b1, rm[6:0]});
    wr(8'h09, 8'h08);
    cwrc_host_model_inst.freq(acc);
    check("accept", 8'(acc), 8'h01);
    step(1);
    check("fc_pulse", 8'(sys_reset_pulse), 8'h01);
    step(130);
    check("pulse_width", 8'(cwrc_host_model_inst.rst_width), 8'd125);
    wr(8'h09, 8'h12);
    cwrc_host_model_inst.freq(acc);
    step(3);
    check("no_fc_pulse", 8'(sys_reset_pulse), 8'h00);
    $display("test frequency reset done");
    wr(8'h09, 8'h00);
    wr(8'h09, 8'h12);
    step(20);
    check("idle_flag", 8'(timeout_flag), 8'h00);
    cwrc_host_model_inst.freq(acc);
    step(8);
    check("early_flag", 8'(timeout_flag), 8'h00);
    wait_flag(20);
    check("flag", 8'(timeout_flag), 8'h01);
    step(2);
    check("locked", 8'(recovery_active), 8'h01);
    check("use_nm", 8'(recovery_use_nm), 8'h01);
    check("wd_pulse", 8'(sys_reset_pulse), 8'h01);
    cwrc_host_model_inst.freq(acc);
    check("locked_accept", 8'(acc), 8'h00);
    rd(8'h09, 8'h16);
    wr(8'h09, 8'h12);
    check("flag_w0", 8'(timeout_flag), 8'h01);
    wr(8'h09, 8'h16);
    check("flag_w1", 8'(timeout_flag), 8'h00);
    check("still_locked", 8'(recovery_active), 8'h01);
    // software unlocks by clearing the enable
    wr(8'h09, 8'h10);
    check("unlocked", 8'(recovery_active), 8'h00);
    cwrc_host_model_inst.freq(acc);
    check("unlock_accept", 8'(acc), 8'h01);
    $display("test recovery lock done");
    step(130);
    @(posedge clk);
    timeout_value <= 5'h01;
    timeout_prescale <= 1'b1;
    wr(8'h0c, {1'b0, rm[6:0]});
    wr(8'h09, 8'h02);
    cwrc_host_model_inst.freq(acc);
    step(4);
    wr(8'h09, 8'h00);
    step(30);
    check("stopped", 8'(timeout_flag), 8'h00);
    wr(8'h09, 8'h02);
    cwrc_host_model_inst.freq(acc);
    step(4);
    check("reloaded", 8'(timeout_flag), 8'h00);
    wait_flag(20);
    check("flag2", 8'(timeout_flag), 8'h01);
    step(2);
    check("use_strap", 8'(recovery_use_strap), 8'h01);
    check("nm_off", 8'(recovery_use_nm), 8'h00);
    check("no_wd_pulse", 8'(sys_reset_pulse), 8'h00);
    $display("test strap recovery done");
    step(4);
    results();
  end
endmodule : tb_clock_watchdog_recovery_ctrl
